// ==== hdl/upf_port.v ====
// Overview of operation
// - Read strobe low drives the receive byte out, else the bus is free.
// - Each read strobe fall fetches the next receive byte, if one is held.
// - Each write strobe fall puts the data bus byte into the transmit buffer, if it has room.
// - Space output is low while a byte can be taken; writes only then.
// - Receive flag is low while data is held; reads only then.
// - During reset both status outputs are released to high impedance.
// - Wakeup enabled and supply switch at 1 turn the receive flag to input.
// - That pin held low for at least 20 ms in suspend requests resume.
// - Send-now asserted while active flushes pending transmit data at once.
// - Send-now asserted while suspended requests resume signalling.
// - The active-low reset input resets the port; high is not asserted.
// - With pull-low set, input-mode pins are pulled low during suspend.
// - The two auxiliary pin functions come from configuration settings.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "upf_consts.vh"

module upf_port #(
  parameter RX_AW         = 4,
  parameter WAKE_HOLD_CYC = `UPF_WAKE_HOLD_CYC
) (
  input  wire        REF_CLK,
  input  wire        RSTN,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  // Parallel FIFO pins
  input  wire [7:0]  FIFO_DATA_BUS_I,
  output wire [7:0]  FIFO_DATA_BUS_O,
  output wire        FIFO_DATA_BUS_OE,
  input  wire        RD_N,
  input  wire        WR,
  output wire        TX_SPACE_N_O,
  output wire        TX_SPACE_N_OE,
  input  wire        RX_AVAIL_N_I,
  output wire        RX_AVAIL_N_O,
  output wire        RX_AVAIL_N_OE,
  input  wire        SEND_NOW_WAKE_N,
  input  wire        SUPPLY_SWITCH_N,
  output wire        INPUT_PULL_LOW,
  output wire [3:0]  AUX_CFG_PIN_A_FUNC,
  output wire [3:0]  AUX_CFG_PIN_B_FUNC,
  // USB engine side
  input  wire        RX_IN_VALID,
  output wire        RX_IN_READY,
  input  wire [7:0]  RX_IN_DATA,
  output wire        TX_OUT_VALID,
  input  wire        TX_OUT_READY,
  output wire [7:0]  TX_OUT_DATA,
  output wire        TX_FLUSH,
  output wire        RESUME_REQ
);

  localparam RX_DEPTH = 1 << RX_AW;

  // Wake detector states, one-hot
  localparam [2:0] WK_IDLE = 3'h1;
  localparam [2:0] WK_HOLD = 3'h2;
  localparam [2:0] WK_DONE = 3'h4;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg  [31:0]      cfg_q;
  reg              overrun_q;
  reg              underrun_q;
  reg              oe_en_q;
  reg  [7:0]       rd_byte_q;
  reg  [7:0]       wr_pipe1_q;
  reg  [7:0]       wr_pipe2_q;
  reg  [7:0]       rx_mem_q [0:RX_DEPTH-1];
  reg  [RX_AW-1:0] rx_wp_q;
  reg  [RX_AW-1:0] rx_rp_q;
  reg  [RX_AW:0]   rx_cnt_q;
  reg  [2:0]       wk_state_q;
  reg  [2:0]       wk_state_d;
  reg  [31:0]      wk_cnt_q;
  reg              flush_q;
  reg              resume_q;
  reg  [31:0]      rdata;
  wire [3:0]       sync_level;
  wire [3:0]       sync_fall;
  wire             rd_low;
  wire             rd_fall;
  wire             wr_fall;
  wire             send_now_fall;
  wire             pin_wake_low;
  wire             suspended;
  wire             wake_pin_input;
  wire             rx_empty;
  wire             rx_full;
  wire             rx_push;
  wire             rx_pop;
  wire             tx_in_ready;
  wire             tx_push;
  wire             apb_wr;
  wire             addr_ok;

  // --------------------------------------------------------------------
  // Strobe and pin synchronisers
  // --------------------------------------------------------------------
  // Bit 0 read strobe, 1 write strobe, 2 send-now, 3 wake pin
  upf_edge_sync #(
    .W       (4),
    .RST_VAL (4'hd)
  ) u_sync (
    .clk      (REF_CLK),
    .rstn     (RSTN),
    .async_in ({RX_AVAIL_N_I, SEND_NOW_WAKE_N, WR, RD_N}),
    .level    (sync_level),
    .fall     (sync_fall)
  );

  assign rd_low       = ~sync_level[0];
  assign rd_fall      = sync_fall[0];
  assign wr_fall      = sync_fall[1];
  assign send_now_fall = sync_fall[2];
  assign pin_wake_low = ~sync_level[3];

  // Supply switch output reading 1 means USB is suspended
  assign suspended      = SUPPLY_SWITCH_N;
  assign wake_pin_input = cfg_q[`UPF_CFG_WAKE_EN] & suspended;

  // --------------------------------------------------------------------
  // Output enables
  // --------------------------------------------------------------------
  // Released by reset, taken up on the first edge after release
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      oe_en_q <= 1'b0;
    end else begin
      oe_en_q <= 1'b1;
    end
  end

  assign TX_SPACE_N_OE    = oe_en_q;
  assign RX_AVAIL_N_OE    = oe_en_q & ~wake_pin_input;
  assign TX_SPACE_N_O     = ~tx_in_ready;
  assign RX_AVAIL_N_O     = rx_empty;
  // Uses the synced strobe, so the bus turns on two edges after the fall
  assign FIFO_DATA_BUS_OE = oe_en_q & rd_low;
  assign FIFO_DATA_BUS_O  = rd_byte_q;

  // --------------------------------------------------------------------
  // Receive FIFO
  // --------------------------------------------------------------------
  assign rx_empty    = (rx_cnt_q == {(RX_AW+1){1'b0}});
  assign rx_full     = rx_cnt_q[RX_AW];
  assign RX_IN_READY = ~rx_full;
  assign rx_push     = RX_IN_VALID & ~rx_full;
  assign rx_pop      = rd_fall & ~rx_empty;

  // Storage itself is not reset; the count guards every read
  always @(posedge REF_CLK) begin
    if (rx_push) begin
      rx_mem_q[rx_wp_q] <= RX_IN_DATA;
    end
  end

  // Pointers, occupancy and the byte shown on the bus
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_wp_q   <= {RX_AW{1'b0}};
      rx_rp_q   <= {RX_AW{1'b0}};
      rx_cnt_q  <= {(RX_AW+1){1'b0}};
      rd_byte_q <= 8'h00;
    end else begin
      if (rx_push) begin
        rx_wp_q <= rx_wp_q + {{(RX_AW-1){1'b0}}, 1'b1};
      end
      if (rx_pop) begin
        rx_rp_q   <= rx_rp_q + {{(RX_AW-1){1'b0}}, 1'b1};
        rd_byte_q <= rx_mem_q[rx_rp_q];
      end
      rx_cnt_q <= rx_cnt_q + {{RX_AW{1'b0}}, rx_push}
                           - {{RX_AW{1'b0}}, rx_pop};
    end
  end

  // --------------------------------------------------------------------
  // Transmit path
  // --------------------------------------------------------------------
  // Data is delayed as far as the write strobe so both line up
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pipe1_q <= 8'h00;
      wr_pipe2_q <= 8'h00;
    end else begin
      wr_pipe1_q <= FIFO_DATA_BUS_I;
      wr_pipe2_q <= wr_pipe1_q;
    end
  end

  assign tx_push = wr_fall;

  // A stalled USB engine fills this and raises the space output
  upf_fifo2 #(
    .W (8)
  ) u_tx_buf (
    .clk       (REF_CLK),
    .rstn      (RSTN),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (wr_pipe2_q),
    .out_valid (TX_OUT_VALID),
    .out_ready (TX_OUT_READY),
    .out_data  (TX_OUT_DATA)
  );

  // --------------------------------------------------------------------
  // Send-now and remote wakeup
  // --------------------------------------------------------------------
  // Wake pin held low while it is an input; timing starts over on release
  always @* begin
    wk_state_d = wk_state_q;
    case (wk_state_q)
      WK_IDLE: begin
        if (wake_pin_input && pin_wake_low) begin
          wk_state_d = WK_HOLD;
        end
      end
      WK_HOLD: begin
        if (!wake_pin_input || !pin_wake_low) begin
          wk_state_d = WK_IDLE;
        end else if (wk_cnt_q >= WAKE_HOLD_CYC - 1) begin
          wk_state_d = WK_DONE;
        end
      end
      WK_DONE: begin
        // One request per hold; wait for the pin to rise again
        if (!wake_pin_input || !pin_wake_low) begin
          wk_state_d = WK_IDLE;
        end
      end
      default: begin
        wk_state_d = WK_IDLE;
      end
    endcase
  end

  // Hold counter, state, and the one-cycle flush and resume pulses
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wk_state_q <= WK_IDLE;
      wk_cnt_q   <= 32'h0000_0000;
      flush_q    <= 1'b0;
      resume_q   <= 1'b0;
    end else begin
      wk_state_q <= wk_state_d;
      if (wk_state_q == WK_HOLD) begin
        wk_cnt_q <= wk_cnt_q + 32'h0000_0001;
      end else begin
        wk_cnt_q <= 32'h0000_0000;
      end
      flush_q  <= send_now_fall & ~suspended;
      resume_q <= (send_now_fall & suspended)
                | (wk_state_q == WK_HOLD && wk_state_d == WK_DONE);
    end
  end

  assign TX_FLUSH   = flush_q;
  assign RESUME_REQ = resume_q;

  // --------------------------------------------------------------------
  // Pin options
  // --------------------------------------------------------------------
  assign INPUT_PULL_LOW     = cfg_q[`UPF_CFG_PULL_LOW] & suspended;
  assign AUX_CFG_PIN_A_FUNC = cfg_q[`UPF_CFG_AUX_A_LSB +: `UPF_AUX_W];
  assign AUX_CFG_PIN_B_FUNC = cfg_q[`UPF_CFG_AUX_B_LSB +: `UPF_AUX_W];

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  // Zero wait states; unmapped addresses answer with an error
  assign addr_ok = (PADDR == `UPF_OFS_CONFIG) || (PADDR == `UPF_OFS_STATUS);
  assign apb_wr  = PSEL & PENABLE & PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;
  assign PRDATA  = rdata;

  // Configuration and sticky error flags; a new event beats the clear
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_q      <= `UPF_CFG_RESET;
      overrun_q  <= 1'b0;
      underrun_q <= 1'b0;
    end else begin
      if (apb_wr && PADDR == `UPF_OFS_CONFIG) begin
        cfg_q <= PWDATA & 32'h0000_ff03;
      end
      if (wr_fall && !tx_in_ready) begin
        overrun_q <= 1'b1; // Write while full is dropped
      end else if (apb_wr && PADDR == `UPF_OFS_STATUS &&
                   PWDATA[`UPF_ST_OVERRUN]) begin
        overrun_q <= 1'b0;
      end
      if (rd_fall && rx_empty) begin
        underrun_q <= 1'b1; // Read while empty leaves the byte alone
      end else if (apb_wr && PADDR == `UPF_OFS_STATUS &&
                   PWDATA[`UPF_ST_UNDERRUN]) begin
        underrun_q <= 1'b0;
      end
    end
  end

  // Read data mux
  always @* begin
    rdata = 32'h0000_0000;
    if (PADDR == `UPF_OFS_CONFIG) begin
      rdata = cfg_q;
    end else if (PADDR == `UPF_OFS_STATUS) begin
      rdata[`UPF_ST_RX_AVAIL]  = ~rx_empty;
      rdata[`UPF_ST_TX_SPACE]  = tx_in_ready;
      rdata[`UPF_ST_SUSPENDED] = suspended;
      rdata[`UPF_ST_OVERRUN]   = overrun_q;
      rdata[`UPF_ST_UNDERRUN]  = underrun_q;
      rdata[`UPF_ST_CNT_LSB +: RX_AW+1] = rx_cnt_q;
    end
  end

endmodule // upf_port

// ==== hdl/upf_consts.vh ====
`ifndef UPF_CONSTS_VH
`define UPF_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the APB side)
// ----------------------------------------------------------------------
`define UPF_OFS_CONFIG      8'h00
`define UPF_OFS_STATUS      8'h04

// ----------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------
`define UPF_CFG_WAKE_EN     0
`define UPF_CFG_PULL_LOW    1
`define UPF_CFG_AUX_A_LSB   8
`define UPF_CFG_AUX_B_LSB   12
`define UPF_AUX_W           4
`define UPF_CFG_RESET       32'h0000_0000

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define UPF_ST_RX_AVAIL     0
`define UPF_ST_TX_SPACE     1
`define UPF_ST_SUSPENDED    2
`define UPF_ST_OVERRUN      3
`define UPF_ST_UNDERRUN     4
`define UPF_ST_CNT_LSB      16

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define UPF_CLK_MHZ         125
`define UPF_WAKE_HOLD_MS    20
`define UPF_WAKE_HOLD_CYC   (`UPF_WAKE_HOLD_MS * `UPF_CLK_MHZ * 1000)

`endif

// ==== hdl/upf_edge_sync.v ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Two-flop synchroniser with falling-edge detect, one lane per bit
// ----------------------------------------------------------------------
module upf_edge_sync #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] level,
  output wire [W-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_lane
      reg meta_q;
      reg sync_q;
      reg prev_q;

      // First stage feeds only the second; edge logic looks at later ones
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_q <= RST_VAL[i];
          sync_q <= RST_VAL[i];
          prev_q <= RST_VAL[i];
        end else begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end

      assign level[i] = sync_q;
      assign fall[i]  = prev_q & ~sync_q;
    end
  endgenerate

endmodule // upf_edge_sync

// ==== hdl/upf_fifo2.v ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Two-entry buffer with valid/ready on both sides
// ----------------------------------------------------------------------
module upf_fifo2 #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem_q [0:1];
  reg         wp_q;
  reg         rp_q;
  reg [1:0]   cnt_q;
  wire        push;
  wire        pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage needs no reset; occupancy guards every read
  always @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // Pointers and occupancy
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // upf_fifo2

// ==== verif/upf_port_asserts.sv ====
`timescale 1ns/1ps
// ---------
// Pin checker
// ---------
module upf_chk (
  input wire REF_CLK,
  input wire RSTN,
  input wire RD_N,
  input wire WR,
  input wire FIFO_DATA_BUS_OE,
  input wire TX_SPACE_N_O,
  input wire TX_SPACE_N_OE,
  input wire RX_AVAIL_N_O,
  input wire RX_AVAIL_N_OE,
  input wire RX_IN_VALID,
  input wire RX_IN_READY,
  input wire TX_OUT_VALID,
  input wire SEND_NOW_WAKE_N,
  input wire SUPPLY_SWITCH_N,
  input wire TX_FLUSH,
  input wire RESUME_REQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  // Strobe edges; sync and detect cost up to three edges
  sequence s_wr_fall;
    $fell(WR) && !TX_SPACE_N_O;
  endsequence
  sequence s_snw_fall;
    $fell(SEND_NOW_WAKE_N);
  endsequence

  a_bus_drive: assert property (
    FIFO_DATA_BUS_OE == !$past(RD_N, 2))
    else $error("Data bus drive not tied to read strobe");
  a_status_tri: assert property (
    disable iff (1'b0) !RSTN |-> !TX_SPACE_N_OE && !RX_AVAIL_N_OE)
    else $error("Status pin driven in reset");
  a_wake_input: assert property (
    !SUPPLY_SWITCH_N [*4] |-> RX_AVAIL_N_OE)
    else $error("Receive flag pin released while awake");
  a_tx_push: assert property (
    s_wr_fall |-> ##[2:4] TX_OUT_VALID)
    else $error("Written byte not buffered");
  a_space_free: assert property (
    !TX_OUT_VALID |-> !TX_SPACE_N_O)
    else $error("No space shown with empty buffer");
  a_rx_flag: assert property (
    RX_IN_VALID && RX_IN_READY |-> ##[1:2] !RX_AVAIL_N_O)
    else $error("Receive flag not low after push");
  a_flush_pulse: assert property (
    s_snw_fall ##0 !SUPPLY_SWITCH_N |-> ##[2:4] TX_FLUSH)
    else $error("No flush after send-now");
  a_resume_req: assert property (
    s_snw_fall ##0 SUPPLY_SWITCH_N |-> ##[2:4] RESUME_REQ)
    else $error("No resume after send-now in suspend");
  a_pulse_once: assert property (
    TX_FLUSH || RESUME_REQ |=> !TX_FLUSH && !RESUME_REQ)
    else $error("Request pulse longer than one cycle");
endmodule // upf_chk

bind upf_port upf_chk u_chk (.REF_CLK, .RSTN, .RD_N, .WR,
  .FIFO_DATA_BUS_OE, .TX_SPACE_N_O, .TX_SPACE_N_OE, .RX_AVAIL_N_O,
  .RX_AVAIL_N_OE, .RX_IN_VALID, .RX_IN_READY, .TX_OUT_VALID,
  .SEND_NOW_WAKE_N, .SUPPLY_SWITCH_N, .TX_FLUSH, .RESUME_REQ);

// ==== verif/upf_ctrl.sv ====
`timescale 1ns/1ps
// ---------
// Controller on the parallel pins
// ---------
module upf_ctrl (
  input  wire       clk,
  input  wire [7:0] dev_o,
  input  wire       dev_oe,
  input  wire       space_n,
  input  wire       avail_o,
  input  wire       avail_oe,
  output wire [7:0] line,
  output wire       avail_pin,
  output reg        rd_n,
  output reg        wr,
  output reg        snw_n,
  output reg        wake_n
);
  reg [7:0] dq;
  reg       drv;
  int       slow = 0;

  // Released lines settle at their pull-up level
  assign line      = dev_oe ? dev_o : (drv ? dq : 8'hff);
  assign avail_pin = avail_oe ? avail_o : wake_n;

  // Idle strobe levels from time zero
  initial begin
    rd_n = 1'b1;
    wr = 1'b0;
    snw_n = 1'b1;
    wake_n = 1'b1;
    drv = 1'b0;
    dq = 8'h00;
  end

  // Read only on the flag unless told to misbehave; slow adds wait
  task rd(input bit any, output logic [7:0] b);
    @(posedge clk);
    if (any || avail_o === 1'b0) begin
      rd_n <= 1'b0;
      repeat (4 + slow) @(posedge clk);
      b = line;
      rd_n <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask

  // Data held from before the fall until well after it
  task wr_b(input bit any, input logic [7:0] b);
    @(posedge clk);
    if (any || space_n === 1'b0) begin
      dq <= b;
      drv <= 1'b1;
      wr <= 1'b1;
      repeat (3) @(posedge clk);
      wr <= 1'b0;
      repeat (3) @(posedge clk);
      drv <= 1'b0;
    end
  endtask

  // Wake pin held low n cycles, then floats high
  task hold_wake(input int n);
    @(posedge clk);
    wake_n <= 1'b0;
    repeat (n) @(posedge clk);
    wake_n <= 1'b1;
  endtask

  task tap_snw;
    @(posedge clk);
    snw_n <= 1'b0;
    repeat (4) @(posedge clk);
    snw_n <= 1'b1;
  endtask
endmodule // upf_ctrl

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
// ---------
// Port bench
// ---------
module testbench;
  localparam int HOLD = 16;
  logic        clk, rstn, psel, penable, pwrite, sup, err_b;
  logic        rx_v, rx_rdy, tx_v, tx_rdy, flush, resume, pready;
  logic        bus_oe, sp_n, sp_oe, av_o, av_oe, av_pin, pull_low;
  logic        rd_n, wr, snw_n, pslverr;
  logic [3:0]  aux_a, aux_b;
  logic [7:0]  paddr, rx_d, tx_d, bus_o, line, b;
  logic [31:0] pwdata, prdata, rd_w;
  logic [7:0]  txq[$];
  logic [7:0]  pat[3] = '{8'ha1, 8'hb2, 8'hc3};
  int          errors = 0, total_checks = 0, n_fl = 0, n_rs = 0;

  upf_port #(.WAKE_HOLD_CYC(HOLD)) uut (
    .REF_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FIFO_DATA_BUS_I(line),
    .FIFO_DATA_BUS_O(bus_o), .FIFO_DATA_BUS_OE(bus_oe), .RD_N(rd_n),
    .WR(wr), .TX_SPACE_N_O(sp_n), .TX_SPACE_N_OE(sp_oe),
    .RX_AVAIL_N_I(av_pin), .RX_AVAIL_N_O(av_o), .RX_AVAIL_N_OE(av_oe),
    .SEND_NOW_WAKE_N(snw_n), .SUPPLY_SWITCH_N(sup),
    .INPUT_PULL_LOW(pull_low), .AUX_CFG_PIN_A_FUNC(aux_a),
    .AUX_CFG_PIN_B_FUNC(aux_b), .RX_IN_VALID(rx_v), .RX_IN_READY(rx_rdy),
    .RX_IN_DATA(rx_d), .TX_OUT_VALID(tx_v), .TX_OUT_READY(tx_rdy),
    .TX_OUT_DATA(tx_d), .TX_FLUSH(flush), .RESUME_REQ(resume));
  upf_ctrl ctl (.clk(clk), .dev_o(bus_o), .dev_oe(bus_oe), .space_n(sp_n),
    .avail_o(av_o), .avail_oe(av_oe), .line(line), .avail_pin(av_pin),
    .rd_n(rd_n), .wr(wr), .snw_n(snw_n), .wake_n());

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Tests need under a thousand cycles; the limit is generous
  initial begin
    #100000;
    errors++;
    close_out();
  end

  // Pulses and drained bytes on the engine side
  always @(posedge clk) begin
    n_fl <= n_fl + (flush === 1'b1);
    n_rs <= n_rs + (resume === 1'b1);
    if (tx_v === 1'b1 && tx_rdy) txq.push_back(tx_d);
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until ready is sampled high
  task apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd_w = prdata;
    err_b = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task close_out;
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    {rstn, psel, penable, pwrite, sup, rx_v, tx_rdy} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_d = 8'h00;
    repeat (4) @(posedge clk);
    chk({sp_oe, av_oe, bus_oe}, 32'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk({sp_oe, av_oe, sp_n, av_o}, 32'hd);
    // Only the defined fields keep their bits
    apb(1'b1, 8'h00, 32'h1234_5677);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd_w, 32'h0000_5603);
    chk({aux_b, aux_a, pull_low}, 32'hac);
    apb(1'b0, 8'h08, 32'h0);
    chk({err_b, rd_w[30:0]}, 32'h8000_0000);
    // Receive path, reads at varied pace, then one on empty
    foreach (pat[i]) begin
      rx_v <= 1'b1;
      rx_d <= pat[i];
      do @(posedge clk); while (rx_rdy !== 1'b1);
    end
    rx_v <= 1'b0;
    @(posedge clk);
    chk(av_o, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd_w, 32'h0003_0003);
    foreach (pat[i]) begin
      ctl.slow = i * 2;
      ctl.rd(1'b0, b);
      chk(b, pat[i]);
    end
    chk({line, av_o}, 32'h1ff);
    ctl.rd(1'b1, b);
    chk(b, pat[2]);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd_w, 32'h0000_0012);
    // Transmit buffer filled past full while the engine stalls
    ctl.wr_b(1'b0, 8'h5a);
    ctl.wr_b(1'b0, 8'h3c);
    @(posedge clk);
    chk(sp_n, 32'h1);
    ctl.wr_b(1'b1, 8'h99);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd_w, 32'h0000_0018);
    tx_rdy <= 1'b1;
    repeat (4) @(posedge clk);
    chk(txq.size(), 32'h2);
    chk({txq[0], txq[1], 7'h00, sp_n}, 32'h5a3c00);
    // Writing ones clears both sticky flags
    apb(1'b1, 8'h04, 32'h0000_0018);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd_w, 32'h0000_0002);
    // Send-now awake, then suspend and both wake paths
    ctl.tap_snw();
    repeat (4) @(posedge clk);
    chk(n_fl, 32'h1);
    sup <= 1'b1;
    repeat (4) @(posedge clk);
    chk({av_oe, pull_low}, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd_w, 32'h0000_0006);
    ctl.tap_snw();
    repeat (4) @(posedge clk);
    chk(n_rs, 32'h1);
    ctl.hold_wake(HOLD / 2);
    repeat (6) @(posedge clk);
    chk(n_rs, 32'h1);
    ctl.hold_wake(HOLD + 6);
    repeat (6) @(posedge clk);
    chk(n_rs, 32'h2);
    sup <= 1'b0;
    repeat (4) @(posedge clk);
    chk({av_oe, pull_low}, 32'h2);
    // Reset again mid-run: pins released, settings cleared
    rstn <= 1'b0;
    @(posedge clk);
    chk({sp_oe, av_oe, bus_oe, aux_a}, 32'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chk({sp_oe, av_oe, rd_w[29:0]}, 32'hc000_0000);
    close_out();
  end
endmodule // testbench
